/* verilog/flash_host.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_host
  import flash_host_pkg::*;
#(
  parameter int          ADDR_W         = 23,
  parameter int          DATA_W         = 16,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_error,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  input  wire logic              ready_busy_n
);

  state_e              state_r;
  state_e              state_nxt;
  logic                ph_load;
  logic [PHASE_TW-1:0] ph_val;
  logic                ph_expired;
  logic                to_load;
  logic                to_expired;
  logic [DATA_W-1:0]   dq_meta_r;
  logic [DATA_W-1:0]   dq_sync_r;
  logic                rb_meta_r;
  logic                rb_sync_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   wdata_r;
  logic [DATA_W-1:0]   rdata_r;
  logic                err_r;
  logic                tog_prev_r;
  logic                tog_valid_r;
  logic                poll_done;
  logic                in_poll;

  flash_timer #(.W(PHASE_TW)) u_phase (
    .clk      (clk),
    .nrst     (nrst),
    .load     (ph_load),
    .load_val (ph_val),
    .expired  (ph_expired)
  );

  // Long wait, four times the typical erase time; far above every embedded duration
  flash_timer #(.W(TIMEOUT_TW)) u_timeout (
    .clk      (clk),
    .nrst     (nrst),
    .load     (to_load),
    .load_val (TIMEOUT_TW'(TIMEOUT_CYCLES)),
    .expired  (to_expired)
  );

  // Pin inputs are asynchronous to clk
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_meta_r <= '0;
      dq_sync_r <= '0;
      rb_meta_r <= 1'b0;
      rb_sync_r <= 1'b0;
    end
    else
    begin
      dq_meta_r <= flash_dq_i;
      dq_sync_r <= dq_meta_r;
      rb_meta_r <= ready_busy_n;
      rb_sync_r <= rb_meta_r;
    end
  end

  assign in_poll   = (state_r == ST_PL_WAIT) || (state_r == ST_PL_GAP) || (state_r == ST_PL_ACC);
  // Ready pin or a toggle bit that stopped toggling ends the wait
  assign poll_done = rb_sync_r || (tog_valid_r && (tog_prev_r == dq_sync_r[TOGGLE_BIT]));

  always_comb
  begin
    state_nxt = state_r;
    ph_load   = 1'b0;
    ph_val    = '0;
    to_load   = 1'b0;
    unique case (state_r)
      ST_IDLE:
        if (cmd_valid)
        begin
          ph_load = 1'b1;
          unique case (op_e'(cmd_op))
            OP_READ:
            begin
              state_nxt = ST_RD_ACC;
              ph_val    = PHASE_TW'(RD_ACC_CYC);
            end
            OP_WRITE:
            begin
              state_nxt = ST_WR_LOW;
              ph_val    = PHASE_TW'(WR_LOW_CYC);
            end
            OP_POLL:
            begin
              // Status not trusted before it is valid; also covers busy delay
              state_nxt = ST_PL_WAIT;
              ph_val    = PHASE_TW'(POLL_WAIT_CYC);
              to_load   = 1'b1;
            end
            OP_RESET:
            begin
              // Held until a running algorithm has surely ended
              state_nxt = ST_RST_LOW;
              ph_val    = PHASE_TW'(RST_LOW_CYC);
            end
          endcase
        end
      ST_RST_LOW:
        if (ph_expired)
        begin
          state_nxt = ST_RST_REC;
          ph_load   = 1'b1;
          ph_val    = PHASE_TW'(RST_REC_CYC);
        end
      ST_RD_ACC:
        if (ph_expired)
        begin
          // Output enable high again before any write can start
          state_nxt = ST_RD_END;
          ph_load   = 1'b1;
          ph_val    = PHASE_TW'(RD_WR_REC_CYC);
        end
      ST_WR_LOW:
        if (ph_expired)
        begin
          state_nxt = ST_WR_HIGH;
          ph_load   = 1'b1;
          ph_val    = PHASE_TW'(WR_HIGH_CYC);
        end
      ST_RST_REC, ST_RD_END, ST_WR_HIGH:
        if (ph_expired)
          state_nxt = ST_DONE;
      ST_PL_WAIT:
        if (to_expired)
          state_nxt = ST_DONE;
        else if (ph_expired)
        begin
          state_nxt = ST_PL_GAP;
          ph_load   = 1'b1;
          ph_val    = PHASE_TW'(POLL_GAP_CYC);
        end
      ST_PL_GAP:
        if (to_expired)
          state_nxt = ST_DONE;
        else if (ph_expired)
        begin
          state_nxt = ST_PL_ACC;
          ph_load   = 1'b1;
          ph_val    = PHASE_TW'(RD_ACC_CYC);
        end
      ST_PL_ACC:
        if (ph_expired)
        begin
          if (to_expired || poll_done)
            state_nxt = ST_DONE;
          else
          begin
            state_nxt = ST_PL_GAP;
            ph_load   = 1'b1;
            ph_val    = PHASE_TW'(POLL_GAP_CYC);
          end
        end
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_r  <= '0;
      wdata_r <= '0;
    end
    else if (state_r == ST_IDLE && cmd_valid)
    begin
      addr_r  <= cmd_addr;
      wdata_r <= cmd_wdata;
    end
  end

  // Pins follow the next state so they change with the state itself
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flash_addr    <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end
    else
    begin
      flash_addr    <= (state_r == ST_IDLE && cmd_valid) ? cmd_addr : addr_r;
      flash_dq_o    <= (state_r == ST_IDLE && cmd_valid) ? cmd_wdata : wdata_r;
      flash_dq_oe   <= (state_nxt == ST_WR_LOW) || (state_nxt == ST_WR_HIGH);
      flash_ce_n    <= !((state_nxt == ST_RD_ACC) || (state_nxt == ST_WR_LOW) ||
                         (state_nxt == ST_PL_GAP) || (state_nxt == ST_PL_ACC));
      flash_oe_n    <= !((state_nxt == ST_RD_ACC) || (state_nxt == ST_PL_ACC));
      flash_we_n    <= !(state_nxt == ST_WR_LOW);
      flash_reset_n <= !(state_nxt == ST_RST_LOW);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r     <= '0;
      tog_prev_r  <= 1'b0;
      tog_valid_r <= 1'b0;
    end
    else if (state_r == ST_PL_WAIT)
      tog_valid_r <= 1'b0;
    else if (ph_expired && (state_r == ST_RD_ACC || state_r == ST_PL_ACC))
    begin
      rdata_r     <= dq_sync_r;
      tog_prev_r  <= dq_sync_r[TOGGLE_BIT];
      tog_valid_r <= 1'b1;
    end
  end

  // Busy beyond the limit is a failure, not a hang
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      err_r <= 1'b0;
    else if (state_r == ST_DONE)
      err_r <= 1'b0;
    else if (in_poll && state_nxt == ST_DONE)
      err_r <= to_expired && !poll_done;
  end

  assign cmd_ready = (state_r == ST_IDLE);
  assign rsp_valid = (state_r == ST_DONE);
  assign rsp_rdata = rdata_r;
  assign rsp_error = err_r;

endmodule : flash_host
`default_nettype wire

/* verilog/flash_host_pkg.sv */
package flash_host_pkg;

  localparam int CLK_PERIOD_NS        = 40;
  // Slowest speed grade, so one build serves every grade
  localparam int BUS_CYCLE_NS         = 120;
  localparam int WRITE_PULSE_NS       = 35;
  localparam int WRITE_PULSE_HIGH_NS  = 30;
  localparam int READ_TO_WRITE_NS     = 0;
  localparam int POLL_ADDR_SETUP_NS   = 15;
  localparam int POLL_OE_HIGH_NS      = 20;
  localparam int RESET_PULSE_NS       = 500;
  localparam int RESET_READY_US       = 20;
  localparam int RESET_RELEASE_NS     = 50;
  localparam int BUSY_DELAY_NS        = 90;
  localparam int POLL_VALID_US        = 4;
  localparam int ERASE_TYP_MS         = 500;
  localparam int TIMEOUT_FACTOR       = 4;
  localparam int NS_PER_US            = 1000;
  localparam int CYC_PER_MS           = 1000000 / CLK_PERIOD_NS;
  localparam int SYNC_STAGES          = 2;
  localparam int TOGGLE_BIT           = 6;
  localparam int PHASE_TW             = 10;
  localparam int TIMEOUT_TW           = 32;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    cyc_up = (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  localparam int BUS_CYC        = cyc_up(BUS_CYCLE_NS);
  localparam int RD_ACC_CYC     = BUS_CYC + SYNC_STAGES;
  localparam int WR_LOW_CYC     = cyc_up(WRITE_PULSE_NS);
  localparam int WR_HIGH_CYC    = max2(cyc_up(WRITE_PULSE_HIGH_NS), BUS_CYC - WR_LOW_CYC);
  localparam int RD_WR_REC_CYC  = cyc_up(READ_TO_WRITE_NS);
  localparam int RST_LOW_CYC    = max2(cyc_up(RESET_PULSE_NS), cyc_up(RESET_READY_US * NS_PER_US));
  localparam int RST_REC_CYC    = cyc_up(RESET_RELEASE_NS);
  localparam int POLL_WAIT_CYC  = max2(cyc_up(POLL_VALID_US * NS_PER_US),
                                       cyc_up(BUSY_DELAY_NS) + SYNC_STAGES);
  localparam int POLL_GAP_CYC   = max2(cyc_up(POLL_ADDR_SETUP_NS), cyc_up(POLL_OE_HIGH_NS));
  localparam int TIMEOUT_CYC    = ERASE_TYP_MS * CYC_PER_MS * TIMEOUT_FACTOR;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_POLL  = 2'h2,
    OP_RESET = 2'h3
  } op_e;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RD_ACC  = 4'h1,
    ST_RD_END  = 4'h3,
    ST_WR_LOW  = 4'h2,
    ST_WR_HIGH = 4'h6,
    ST_PL_WAIT = 4'h7,
    ST_PL_GAP  = 4'h5,
    ST_PL_ACC  = 4'h4,
    ST_RST_LOW = 4'hC,
    ST_RST_REC = 4'hD,
    ST_DONE    = 4'hF
  } state_e;

endpackage : flash_host_pkg

/* verilog/flash_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_timer #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (load)
      cnt_r <= load_val;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  assign expired = (cnt_r == '0);

endmodule : flash_timer
`default_nettype wire

/* bench/flash_host_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_host_monitor #(
  parameter int          ADDR_W         = 23,
  parameter int unsigned TIMEOUT_CYCLES = 2000
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [1:0]        cmd_op,
  input wire logic              rsp_valid,
  input wire logic              rsp_error,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  input wire logic              flash_reset_n
);
  logic [31:0] busy_cnt_r;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= cmd_ready ? 32'h0 : busy_cnt_r + 32'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rst_rec_a: assert property ($rose(flash_reset_n) |-> (flash_oe_n && flash_ce_n) [*2])
    else $error("read started too soon after reset");
  addr_setup_a: assert property ($fell(flash_oe_n) && !$fell(flash_ce_n) |-> $stable(flash_addr))
    else $error("poll address not settled");
  oe_gap_a: assert property (!flash_ce_n && $rose(flash_oe_n) |=> flash_oe_n)
    else $error("output enable gap too short");
  acc_len_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5])
    else $error("access shorter than five cycles");
  wr_cycle_a: assert property ($fell(flash_we_n) |-> flash_dq_oe [*3])
    else $error("write cycle too short");
  wr_high_a: assert property ($rose(flash_we_n) |-> flash_we_n [*2])
    else $error("write enable high too short");
  rd_wr_a: assert property (!flash_we_n |-> flash_oe_n && $past(flash_oe_n))
    else $error("write while output enabled");
  poll_wait_a: assert property (cmd_valid && cmd_ready && cmd_op == 2'h2 |=> flash_oe_n throughout (##100 1'b1))
    else $error("status read too early");
  tmo_err_a: assert property (rsp_error |-> rsp_valid && busy_cnt_r + 4 >= TIMEOUT_CYCLES && busy_cnt_r <= TIMEOUT_CYCLES + 8)
    else $error("timeout flagged at wrong time");

  cover property (rsp_valid && rsp_error);
  cover property ($rose(flash_reset_n));
  cover property ($fell(flash_we_n));
endmodule : flash_host_monitor

bind flash_host flash_host_monitor #(.ADDR_W(ADDR_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_error, .flash_addr,
  .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n
);
`default_nettype wire

/* bench/flash_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model (
  input wire logic [3:0]  addr,
  input wire logic [15:0] din,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        rst_n,
  input var  int          busy_ns,
  output logic [15:0]     dout,
  output logic            ready_busy_n = 1'b1
);
  logic [15:0] mem [16];
  logic [15:0] cur;
  logic [15:0] last = 16'h0;
  logic        tgl = 1'b0;
  int          gen = 0;

  assign cur = ready_busy_n ? mem[addr] : (tgl ? 16'h0040 : 16'h0000);
  // Released bus shows inverted history, never a stale value
  assign dout = (!ce_n && !oe_n) ? cur : ~last;

  always @(posedge oe_n)
  begin
    last = cur;
    if (!ready_busy_n)
      tgl = !tgl;
  end

  task automatic run(input int g, input int t);
    #60;
    if (g == gen)
      ready_busy_n = 1'b0;
    #(t);
    if (g == gen)
      ready_busy_n = 1'b1;
  endtask : run

  always @(posedge we_n)
    if (!$isunknown(addr))
    begin
      mem[addr] = din;
      gen++;
      if (busy_ns > 0)
        fork
          run(gen, busy_ns);
        join_none
    end

  // Reset cancels any pending completion
  always @(negedge rst_n)
  begin
    gen++;
    #500 ready_busy_n = 1'b1;
  end
endmodule : flash_dev_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op = 2'h0;
  logic [22:0] cmd_addr = 23'h0;
  logic [15:0] cmd_wdata = 16'h0;
  logic        cmd_ready, rsp_valid, rsp_error, dq_oe, ce_n, oe_n, we_n, rst_n, rb_n;
  logic [22:0] f_addr;
  logic [15:0] rdata, dq_o, dev_dq, dq_w;
  int          errors = 0;
  int          checks = 0;
  int          busy_ns = 0;
  int          n;

  assign dq_w = dq_oe ? dq_o : dev_dq;
  always #20 clk = ~clk;

  flash_host #(.TIMEOUT_CYCLES(2000)) u_dut (
    .clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid,
    .rsp_rdata(rdata), .rsp_error, .flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_dq_i(dq_w), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(rst_n), .ready_busy_n(rb_n)
  );
  flash_dev_model u_dev (
    .addr(f_addr[3:0]), .din(dq_w), .ce_n, .oe_n, .we_n, .rst_n, .busy_ns,
    .dout(dev_dq), .ready_busy_n(rb_n)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi)
    begin
      errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask : chk_rng

  // Edges from take to the response cycle land in n
  task automatic cmd(input logic [1:0] op, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = {19'h0, a};
    cmd_wdata = d;
    // Request stands until an edge that sees the block idle
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : cmd

  task automatic t_wr_rd;
    cmd(2'h1, 4'h3, 16'hA5C3);
    chk_rng("write cycles", 5, 5);
    cmd(2'h0, 4'h3, 16'h0);
    chk_rng("read cycles", 8, 8);
    chk("read data", 16'hA5C3, rdata);
    cmd(2'h1, 4'h4, 16'h5A3C);
    cmd(2'h0, 4'h4, 16'h0);
    chk("read after write", 16'h5A3C, rdata);
  endtask : t_wr_rd

  task automatic t_poll_busy;
    busy_ns = 20000;
    cmd(2'h1, 4'h5, 16'h1234);
    cmd(2'h2, 4'h5, 16'h0);
    chk_rng("busy poll cycles", 490, 515);
    chk("busy poll error", 16'h0, {15'h0, rsp_error});
    chk("busy poll data", 16'h1234, rdata);
  endtask : t_poll_busy

  task automatic t_tmo_reset;
    busy_ns = 1000000000;
    cmd(2'h1, 4'h6, 16'h0F0F);
    cmd(2'h2, 4'h6, 16'h0);
    chk("timeout error", 16'h1, {15'h0, rsp_error});
    chk_rng("timeout cycles", 1990, 2010);
    cmd(2'h3, 4'h0, 16'h0);
    chk_rng("reset cycles", 504, 504);
    chk("ready after reset", 16'h1, {15'h0, rb_n});
    cmd(2'h0, 4'h6, 16'h0);
    chk("data after reset", 16'h0F0F, rdata);
    cmd(2'h2, 4'h6, 16'h0);
    chk_rng("idle poll cycles", 100, 112);
    chk("idle poll error", 16'h0, {15'h0, rsp_error});
  endtask : t_tmo_reset

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    t_wr_rd();
    t_poll_busy();
    t_tmo_reset();
    tally_and_finish();
  end

  // About three thousand two hundred cycles expected
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
